// ---- design/bcm_consts.svh ----
/*
 Offsets, field positions, reset values and fixed codes of the bridge
 configuration slice. Assumes 8-bit byte addresses on a 32-bit register port.
*/
`ifndef BCM_CONSTS_SVH
`define BCM_CONSTS_SVH

`define BCM_ADDR_W 8
`define BCM_DATA_W 32

`define BCM_OFF_STRAP 8'hC8
`define BCM_OFF_GPIO 8'hD8
`define BCM_OFF_EE 8'hDC
`define BCM_OFF_CAP 8'hE0

`define BCM_STRAP_W 14
`define BCM_STRAP_RST 14'h0000
`define BCM_STRAP_SETTLE 2'h2

`define BCM_GPIO_N 8
`define BCM_GPIO_IN_LO 0
`define BCM_GPIO_DIR_LO 8
`define BCM_GPIO_OUT_LO 16
`define BCM_GPIO_RST 8'h00

`define BCM_EE_START_BIT 0
`define BCM_EE_PRELOAD_BIT 2
`define BCM_EE_OP_LO 3
`define BCM_EE_OP_W 2
`define BCM_EE_ADDR_LO 5
`define BCM_EE_ADDR_W 11
`define BCM_EE_DATA_LO 16
`define BCM_EE_DATA_W 16
`define BCM_EE_OP_RST 2'h0
`define BCM_EE_ADDR_RST 11'h000
`define BCM_EE_DATA_RST 16'h0000
`define BCM_EE_OP_WRITE 2'h1
`define BCM_EE_OP_READ 2'h2

`define BCM_CAP_ID 8'h10
`define BCM_CAP_NEXT 8'h00
`define BCM_CAP_VER 4'h1
`define BCM_CAP_TYPE 4'h1
`define BCM_CAP_SLOT 1'h0
`define BCM_CAP_MSG 5'h00
`define BCM_CAP_RSVD 2'h0

`define BCM_ZERO32 32'h0000_0000

`endif

// ---- design/bcm_pkg.sv ----
/*
 Types of the bridge configuration slice.
 Assumes bcm_consts.svh is included by the modules that need constants.
*/
package bcm_pkg;

    typedef enum logic [1:0] {
        BCM_EE_IDLE = 2'h0,
        BCM_EE_BUSY = 2'h1
    } bcm_ee_state_t;

endpackage : bcm_pkg

// ---- design/bcm_regs.sv ----
/*
 Bridge configuration slice: strap status, GPIO control, EEPROM access
 control and the fixed capability header, behind a plain register port.
 Assumes strap and GPIO pins are asynchronous, and that the EEPROM serial
 engine and the auto-load sequencer run on clock_i and pulse their done.
*/
// What this block does
// - Strap bits 0,1 show low/high drive straps
// - Bits 5:2 current, 9:6 de-emphasis straps
// - Bits 11:10 rx, 13:12 tx termination straps
// - Straps default to pins; auto-load overrides
// - GPIO input bits return present pin levels
// - Direction bits choose input or output per pin
// - Output bits drive pins set as outputs
// - Writing start launches one EEPROM cycle when idle with opcode 01b or 10b
// - Opcode 01b write, 10b read, others reserved
// - Address 15:5 and write data 31:16 held
// - Capability ID reads constant 10h
// - Next capability pointer reads 00h
// - Capability version reads 0001b
// - Device/port type reads 1h, legacy endpoint
// - Slot bit and message number read zero
`timescale 1ns/10ps
`include "bcm_consts.svh"

module bcm_regs
    import bcm_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [`BCM_ADDR_W-1:0] addr_i,
    input wire logic [`BCM_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`BCM_DATA_W-1:0] rdata_o,
    input wire logic low_drive_strap_i,
    input wire logic high_drive_strap_i,
    input wire logic [3:0] tx_current_straps_i,
    input wire logic [3:0] tx_deemphasis_straps_i,
    input wire logic [1:0] rx_termination_straps_i,
    input wire logic [1:0] tx_termination_straps_i,
    input wire logic autoload_done_i,
    input wire logic [`BCM_STRAP_W-1:0] autoload_straps_i,
    input wire logic [`BCM_GPIO_N-1:0] gpio_i,
    output logic [`BCM_GPIO_N-1:0] gpio_o,
    output logic [`BCM_GPIO_N-1:0] gpio_oe_o,
    output logic ee_start_o,
    output logic [`BCM_EE_OP_W-1:0] ee_op_o,
    output logic [`BCM_EE_ADDR_W-1:0] ee_addr_o,
    output logic [`BCM_EE_DATA_W-1:0] ee_wdata_o,
    output logic ee_preload_o,
    output logic ee_busy_o,
    input wire logic ee_done_i
);

    logic [`BCM_STRAP_W-1:0] strap_pins;
    logic [`BCM_STRAP_W-1:0] strap_s1_r;
    logic [`BCM_STRAP_W-1:0] strap_s2_r;
    logic [`BCM_STRAP_W-1:0] strap_r;
    logic [1:0] settle_r;
    logic strap_held_r;
    logic [`BCM_GPIO_N-1:0] gpio_s1_r;
    logic [`BCM_GPIO_N-1:0] gpio_in_r;
    logic [`BCM_GPIO_N-1:0] gpio_dir_r;
    logic [`BCM_GPIO_N-1:0] gpio_out_r;
    logic ee_start_r;
    logic ee_preload_r;
    logic [`BCM_EE_OP_W-1:0] ee_op_r;
    logic [`BCM_EE_ADDR_W-1:0] ee_addr_r;
    logic [`BCM_EE_DATA_W-1:0] ee_data_r;
    logic ee_pulse_r;
    bcm_ee_state_t ee_state_r;
    bcm_ee_state_t ee_state_nxt;
    logic [`BCM_DATA_W-1:0] rdata_nxt;
    logic [`BCM_DATA_W-1:0] rdata_r;
    logic wr_gpio;
    logic wr_ee;
    logic [`BCM_EE_OP_W-1:0] wr_op;
    logic op_valid;
    logic launch;

    assign wr_gpio = wr_i && (addr_i == `BCM_OFF_GPIO);
    assign wr_ee = wr_i && (addr_i == `BCM_OFF_EE);
    assign wr_op = wdata_i[`BCM_EE_OP_LO +: `BCM_EE_OP_W];
    assign op_valid = (wr_op == `BCM_EE_OP_WRITE) || (wr_op == `BCM_EE_OP_READ);
    // Reserved opcodes are held in ee_op_r but never start the serial engine
    assign launch = wr_ee && wdata_i[`BCM_EE_START_BIT] && op_valid
                    && (ee_state_r == BCM_EE_IDLE);

    assign strap_pins = {tx_termination_straps_i, rx_termination_straps_i,
                         tx_deemphasis_straps_i, tx_current_straps_i,
                         high_drive_strap_i, low_drive_strap_i};

    // Strap pins are asynchronous to the core clock
    // Only the second stage feeds the capture, never the first
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            strap_s1_r <= `BCM_STRAP_RST;
            strap_s2_r <= `BCM_STRAP_RST;
        end
        else
        begin
            strap_s1_r <= strap_pins;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Pins are caught once, after the synchroniser has filled; an auto-load
    // that finishes later replaces them and always wins
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            strap_r <= `BCM_STRAP_RST;
            settle_r <= 2'h0;
            strap_held_r <= 1'b0;
        end
        else if (autoload_done_i)
        begin
            strap_r <= autoload_straps_i;
            strap_held_r <= 1'b1;
        end
        else if (!strap_held_r)
        begin
            if (settle_r == `BCM_STRAP_SETTLE)
            begin
                strap_r <= strap_s2_r;
                strap_held_r <= 1'b1;
            end
            else
            begin
                settle_r <= settle_r + 2'h1;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `BCM_GPIO_N; gi++)
        begin : g_gpio
            always_ff @(posedge clock_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    gpio_s1_r[gi] <= 1'b0;
                    gpio_in_r[gi] <= 1'b0;
                end
                else
                begin
                    gpio_s1_r[gi] <= gpio_i[gi];
                    gpio_in_r[gi] <= gpio_s1_r[gi];
                end
            end

            always_ff @(posedge clock_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    gpio_dir_r[gi] <= 1'b0;
                    gpio_out_r[gi] <= 1'b0;
                end
                else if (wr_gpio)
                begin
                    gpio_dir_r[gi] <= wdata_i[`BCM_GPIO_DIR_LO + gi];
                    gpio_out_r[gi] <= wdata_i[`BCM_GPIO_OUT_LO + gi];
                end
            end
        end
    endgenerate

    // The level is always held, but only reaches the pin while enabled
    assign gpio_o = gpio_out_r;
    assign gpio_oe_o = gpio_dir_r;

    always_comb
    begin
        ee_state_nxt = ee_state_r;
        case (ee_state_r)
            BCM_EE_IDLE:
            begin
                if (launch)
                begin
                    ee_state_nxt = BCM_EE_BUSY;
                end
            end
            BCM_EE_BUSY:
            begin
                if (ee_done_i)
                begin
                    ee_state_nxt = BCM_EE_IDLE;
                end
            end
            default:
            begin
                ee_state_nxt = BCM_EE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ee_state_r <= BCM_EE_IDLE;
        end
        else
        begin
            ee_state_r <= ee_state_nxt;
        end
    end

    // Start stays set for the whole cycle so software can poll it
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ee_start_r <= 1'b0;
            ee_pulse_r <= 1'b0;
        end
        else
        begin
            ee_pulse_r <= launch;
            if (launch)
            begin
                ee_start_r <= 1'b1;
            end
            else if (ee_done_i && ee_state_r == BCM_EE_BUSY)
            begin
                ee_start_r <= 1'b0;
            end
        end
    end

    // Fields are frozen while a cycle runs so the engine sees stable values
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            ee_preload_r <= 1'b0;
            ee_op_r <= `BCM_EE_OP_RST;
            ee_addr_r <= `BCM_EE_ADDR_RST;
            ee_data_r <= `BCM_EE_DATA_RST;
        end
        else if (wr_ee && ee_state_r == BCM_EE_IDLE)
        begin
            ee_preload_r <= wdata_i[`BCM_EE_PRELOAD_BIT];
            ee_op_r <= wr_op;
            ee_addr_r <= wdata_i[`BCM_EE_ADDR_LO +: `BCM_EE_ADDR_W];
            ee_data_r <= wdata_i[`BCM_EE_DATA_LO +: `BCM_EE_DATA_W];
        end
    end

    assign ee_start_o = ee_pulse_r;
    assign ee_op_o = ee_op_r;
    assign ee_addr_o = ee_addr_r;
    assign ee_wdata_o = ee_data_r;
    assign ee_preload_o = ee_preload_r;
    assign ee_busy_o = ee_start_r;

    always_comb
    begin
        // Unmapped offsets and reserved fields fall through as zero
        rdata_nxt = `BCM_ZERO32;
        case (addr_i)
            `BCM_OFF_STRAP:
            begin
                rdata_nxt[`BCM_STRAP_W-1:0] = strap_r;
            end
            `BCM_OFF_GPIO:
            begin
                rdata_nxt[`BCM_GPIO_IN_LO +: `BCM_GPIO_N] = gpio_in_r;
                rdata_nxt[`BCM_GPIO_DIR_LO +: `BCM_GPIO_N] = gpio_dir_r;
                rdata_nxt[`BCM_GPIO_OUT_LO +: `BCM_GPIO_N] = gpio_out_r;
            end
            `BCM_OFF_EE:
            begin
                rdata_nxt[`BCM_EE_START_BIT] = ee_start_r;
                rdata_nxt[`BCM_EE_PRELOAD_BIT] = ee_preload_r;
                rdata_nxt[`BCM_EE_OP_LO +: `BCM_EE_OP_W] = ee_op_r;
                rdata_nxt[`BCM_EE_ADDR_LO +: `BCM_EE_ADDR_W] = ee_addr_r;
                rdata_nxt[`BCM_EE_DATA_LO +: `BCM_EE_DATA_W] = ee_data_r;
            end
            `BCM_OFF_CAP:
            begin
                rdata_nxt = {`BCM_CAP_RSVD, `BCM_CAP_MSG, `BCM_CAP_SLOT,
                             `BCM_CAP_TYPE, `BCM_CAP_VER,
                             `BCM_CAP_NEXT, `BCM_CAP_ID};
            end
            default:
            begin
                rdata_nxt = `BCM_ZERO32;
            end
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rdata_r <= `BCM_ZERO32;
        end
        else if (rd_i)
        begin
            rdata_r <= rdata_nxt;
        end
        else
        begin
            rdata_r <= `BCM_ZERO32;
        end
    end

    assign rdata_o = rdata_r;

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    strap_read_a: assert property (
        rd_i && addr_i == `BCM_OFF_STRAP |=> rdata_o == {18'h00000, $past(strap_r)})
        else $error("strap word read mismatch");

    autoload_over_a: assert property (
        autoload_done_i |=> strap_r == $past(autoload_straps_i) && strap_held_r)
        else $error("auto-load did not replace straps");

    gpio_in_read_a: assert property (
        rd_i && addr_i == `BCM_OFF_GPIO |=> rdata_o[7:0] == $past(gpio_in_r))
        else $error("gpio input read mismatch");

    gpio_dir_wr_a: assert property (
        wr_gpio |=> gpio_oe_o == $past(wdata_i[15:8]))
        else $error("gpio direction not taken");

    gpio_out_wr_a: assert property (
        wr_gpio ##1 !wr_gpio |-> gpio_o == $past(wdata_i[23:16]))
        else $error("gpio output level not held");

    ee_launch_a: assert property (
        launch |=> ee_start_o && ee_start_r ##1 !ee_start_o)
        else $error("eeprom launch not a single pulse");

    ee_reserved_a: assert property (
        wr_ee && !op_valid && !ee_start_r |=> !ee_start_o && !ee_start_r)
        else $error("reserved opcode launched a cycle");

    ee_fields_a: assert property (
        launch |=> ee_addr_o == $past(wdata_i[15:5]) && ee_wdata_o == $past(wdata_i[31:16]))
        else $error("eeprom address or data not held");

    cap_header_a: assert property (
        rd_i && addr_i == `BCM_OFF_CAP |=> rdata_o == 32'h0011_0010)
        else $error("capability header wrong");

    start_clear_a: assert property (
        ee_done_i && ee_state_r == BCM_EE_BUSY |=> !ee_start_r && ee_state_r == BCM_EE_IDLE)
        else $error("start bit did not clear on completion");

    rsvd_zero_a: assert property (
        rd_i && addr_i == `BCM_OFF_GPIO |=> rdata_o[31:24] == 8'h00)
        else $error("reserved gpio bits not zero");

    strap_capture_a: assert property (
        !strap_held_r && settle_r == `BCM_STRAP_SETTLE && !autoload_done_i |=> strap_r == $past(strap_s2_r))
        else $error("strap pins not captured");

    ee_frozen_a: assert property (
        wr_ee && ee_state_r == BCM_EE_BUSY |=> $stable(ee_addr_o) && $stable(ee_wdata_o) && $stable(ee_op_o))
        else $error("eeprom fields changed while busy");

endmodule : bcm_regs

// ---- verif/bcm_far_side.sv ----
/*
 Far-side model: strap pins, eight GPIO pins and the EEPROM engine.
 Assumes the bench sets strap_lvl, ext_lvl and lat before reset release.
*/
`timescale 1ns/10ps

module bcm_far_side
(
    input wire logic clock_i,
    output logic [13:0] strap_o,
    output logic autoload_done_o,
    output logic [13:0] autoload_straps_o,
    output logic [7:0] pin_o,
    input wire logic [7:0] drive_i,
    input wire logic [7:0] drive_en_i,
    input wire logic ee_start_i,
    output logic ee_done_o
);
    logic [13:0] strap_lvl;
    logic [7:0] ext_lvl;
    int lat;
    int cnt;

    initial
    begin
        cnt = 0;
        ee_done_o = 1'b0;
        autoload_done_o = 1'b0;
        autoload_straps_o = 14'h0000;
    end

    assign strap_o = strap_lvl;
    // No pull on the pins: an input pin sees whatever the board drives
    assign pin_o = (drive_en_i & drive_i) | (~drive_en_i & ext_lvl);

    // Engine answers after lat cycles, so busy windows can be stretched
    always @(posedge clock_i)
    begin
        if (ee_start_i)
            cnt <= lat;
        else if (cnt > 0)
            cnt <= cnt - 1;
        ee_done_o <= (cnt == 1) && !ee_start_i;
    end

    task autoload(input logic [13:0] v);
        @(posedge clock_i);
        autoload_straps_o <= v;
        autoload_done_o <= 1'b1;
        @(posedge clock_i);
        autoload_done_o <= 1'b0;
        autoload_straps_o <= ~v;
    endtask : autoload
endmodule : bcm_far_side

// ---- verif/test_bridge_config_misc_regs.sv ----
/*
 Self-checking bench of the bridge configuration slice.
 Assumes bcm_regs with its constants header, and the far-side model.
*/
`timescale 1ns/10ps
`include "bcm_consts.svh"

module test_bridge_config_misc_regs;
    import bcm_pkg::*;

    logic clock_i = 1'b0;
    logic nrst = 1'b1;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_stb;
    logic rd_stb;
    logic rd_seen = 1'b0;
    logic [31:0] rdata;
    logic [13:0] strap;
    logic al_done;
    logic [13:0] al_val;
    logic [7:0] pins;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;
    logic ee_start;
    logic [1:0] ee_op;
    logic [10:0] ee_addr;
    logic [15:0] ee_wdata;
    logic ee_pre;
    logic ee_busy;
    logic ee_done;
    logic [31:0] rd_q[$];
    logic [29:0] ee_q[$];
    int miscompares = 0;
    int n_checks = 0;

    always #5 clock_i = ~clock_i;

    bcm_regs DUT (
        .clock_i(clock_i), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_stb), .rd_i(rd_stb), .rdata_o(rdata),
        .low_drive_strap_i(strap[0]), .high_drive_strap_i(strap[1]),
        .tx_current_straps_i(strap[5:2]), .tx_deemphasis_straps_i(strap[9:6]),
        .rx_termination_straps_i(strap[11:10]), .tx_termination_straps_i(strap[13:12]),
        .autoload_done_i(al_done), .autoload_straps_i(al_val),
        .gpio_i(pins), .gpio_o(gpio_out), .gpio_oe_o(gpio_oe),
        .ee_start_o(ee_start), .ee_op_o(ee_op), .ee_addr_o(ee_addr),
        .ee_wdata_o(ee_wdata), .ee_preload_o(ee_pre), .ee_busy_o(ee_busy),
        .ee_done_i(ee_done)
    );

    bcm_far_side far (
        .clock_i(clock_i), .strap_o(strap), .autoload_done_o(al_done),
        .autoload_straps_o(al_val), .pin_o(pins), .drive_i(gpio_out),
        .drive_en_i(gpio_oe), .ee_start_i(ee_start), .ee_done_o(ee_done)
    );

    task chk_out(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_out

    task end_of_test;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock_i);
        wr_stb <= 1'b0;
    endtask : bus_wr

    task bus_rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        @(posedge clock_i);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock_i);
        rd_stb <= 1'b0;
    endtask : bus_rd

    // Results are matched against the oldest note as they appear
    always @(posedge clock_i)
    begin
        rd_seen <= rd_stb;
        if (rd_seen)
            chk_out("rdata", rd_q.size() != 0 ? rd_q.pop_front() : ~rdata, rdata);
        else
            chk_out("rdata idle", 32'h0000_0000, rdata);
        if (ee_start === 1'b1)
            chk_out("ee cycle", ee_q.size() != 0 ? {2'h0, ee_q.pop_front()} : 32'hFFFF_FFFF,
                {2'h0, ee_pre, ee_op, ee_addr, ee_wdata});
    end

    initial
    begin
        #50000;
        miscompares++;
        end_of_test();
    end

    initial
    begin
        logic [31:0] v;
        logic [31:0] e;
        logic [13:0] s;
        logic [7:0] d;
        logic [7:0] o;
        logic [7:0] x;
        int n;
        void'($urandom(32'hF6AB));
        nrst <= 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        s = 14'($urandom);
        x = 8'($urandom);
        far.strap_lvl = s;
        far.ext_lvl = x;
        far.lat = 20;
        repeat (5) @(posedge clock_i);
        nrst <= 1'b1;
        repeat (4) @(posedge clock_i);
        bus_rd(`BCM_OFF_STRAP, {18'h0, s});
        bus_rd(`BCM_OFF_GPIO, {24'h0, x});
        bus_rd(`BCM_OFF_EE, 32'h0000_0000);
        bus_rd(`BCM_OFF_CAP, 32'h0011_0010);
        bus_wr(`BCM_OFF_STRAP, 32'hFFFF_FFFF);
        bus_wr(`BCM_OFF_CAP, 32'hFFFF_FFFF);
        bus_wr(8'hE4, 32'hFFFF_FFFF);
        bus_rd(`BCM_OFF_STRAP, {18'h0, s});
        bus_rd(`BCM_OFF_CAP, 32'h0011_0010);
        bus_rd(8'hE4, 32'h0000_0000);
        s = 14'($urandom);
        far.autoload(s);
        bus_rd(`BCM_OFF_STRAP, {18'h0, s});
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
            o = 8'($urandom);
            x = 8'($urandom);
            bus_wr(`BCM_OFF_GPIO, {8'hFF, o, d, 8'hFF});
            far.ext_lvl <= x;
            @(negedge clock_i);
            chk_out("gpio_oe", {24'h0, d}, {24'h0, gpio_oe});
            chk_out("gpio_out", {24'h0, o}, {24'h0, gpio_out});
            repeat (3) @(posedge clock_i);
            bus_rd(`BCM_OFF_GPIO, {8'h00, o, d, (d & o) | (~d & x)});
        end
        for (int k = 0; k < 4; k++)
        begin
            v = $urandom;
            v[1:0] = 2'h3;
            v[4:3] = 2'(k);
            e = v & 32'hFFFF_FFFC;
            if (k == 1 || k == 2)
                ee_q.push_back({v[2], v[4:3], v[15:5], v[31:16]});
            bus_wr(`BCM_OFF_EE, v);
            if (k == 1 || k == 2)
            begin
                bus_rd(`BCM_OFF_EE, e | 32'h1);
                chk_out("ee_busy high", 32'h1, {31'h0, ee_busy});
                bus_wr(`BCM_OFF_EE, ~v);
                for (n = 0; n < 200 && ee_busy !== 1'b0; n++)
                    @(posedge clock_i);
                chk_out("ee_busy", 32'h0, {31'h0, ee_busy});
            end
            bus_rd(`BCM_OFF_EE, e);
        end
        repeat (3) @(posedge clock_i);
        chk_out("pending notes", 32'h0, rd_q.size() + ee_q.size());
        end_of_test();
    end
endmodule : test_bridge_config_misc_regs
